// *** hw/ccs_pkg.sv ***
// Purpose: Shared constants and types for the core clock select and PLL control block
// Assumes: Single 250 MHz clock, register port with one-cycle read latency
// Notes: Register offsets are word addresses on the plain register port
package ccs_pkg;
   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [3:0] CCS_OFF_PLL_CONFIG = 4'h0;
   localparam logic [3:0] CCS_OFF_STATUS = 4'h1;
   localparam logic [3:0] CCS_OFF_RELOCK_TIME = 4'h2;
   localparam logic [3:0] CCS_OFF_COPROC = 4'h3;

   // Field layout
   localparam int CCS_FREQ_W = 5;
   localparam logic [4:0] CCS_FREQ_RESET = 5'h00;
   localparam logic [4:0] CCS_FREQ_MAX_OK = 5'h0B;
   localparam int CCS_ST_STALL_BIT = 0;
   localparam int CCS_ST_SWEN_BIT = 1;
   localparam int CCS_ST_SRC_BIT = 2;
   localparam int CCS_ST_BADCODE_BIT = 3;
   localparam int CCS_CP_OPC_LSB = 4;
   localparam logic [2:0] CCS_OPC_CLOCK = 3'h2;
   localparam logic [3:0] CCS_CRM_ENABLE = 4'h1;
   localparam logic [3:0] CCS_CRM_DISABLE = 4'h2;

   // Timing: relock stall of about 150 us
   localparam int CCS_CLK_MHZ = 250;
   localparam int CCS_RELOCK_US = 150;
   localparam int CCS_RELOCK_CYC = CCS_RELOCK_US * CCS_CLK_MHZ;
   localparam int CCS_RELOCK_W = 24;

   // Clock source of the effective core clock
   typedef enum logic {
      CCS_SRC_MEMORY,
      CCS_SRC_FULL
   } ccs_src_e;

   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ccs_req_s;

   // Gate enables for derived clock groups
   typedef struct packed {
      logic core_pll;
      logic usb_pll;
      logic baud;
      logic periph;
   } ccs_gates_s;
endpackage

// *** hw/ccs_relock_timer.sv ***
// Purpose: Counts the PLL relock interval after a configuration write
// Assumes: Runs on the unaffected reference clock
// Notes: A new start restarts the full interval
`timescale 1ns/1ps
module ccs_relock_timer
   import ccs_pkg::*;
#(
   parameter int W = CCS_RELOCK_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic start,
   input wire logic [W-1:0] interval,
   // Status
   output logic busy
);
   initial begin
      if (W < 2) $error("ccs_relock_timer: width too small");
   end

   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic next_busy;

   // -----------------------------------------------------------------
   // Countdown
   // -----------------------------------------------------------------
   // Zero interval still stalls one cycle so the PLL sees a stop
   always_comb begin
      next_count = count;
      next_busy = busy;
      if (start) begin
         next_count = (interval == '0) ? W'(1) : interval;
         next_busy = 1'b1;
      end else if (busy) begin
         next_count = count - W'(1);
         if (count == W'(1)) next_busy = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= '0;
         busy <= 1'b0;
      end else begin
         count <= next_count;
         busy <= next_busy;
      end
   end
endmodule // ccs_relock_timer

// *** hw/ccs_half_div.sv ***
// Purpose: Divide-by-two enable generator with a stop input
// Assumes: Output is a registered toggle used as a clock enable
// Notes: Stopping holds the phase low so restart is clean
`timescale 1ns/1ps
module ccs_half_div (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic run,
   // Output
   output logic half
);
   logic next_half;

   // Toggle while running, park low while stopped
   always_comb begin
      next_half = run ? ~half : 1'b0;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) half <= 1'b0;
      else half <= next_half;
   end
endmodule // ccs_half_div

// *** hw/ccs_clock_ctrl.sv ***
// Purpose: Core clock source select, frequency select and PLL relock control
// Assumes: Cache-miss wait level comes from the core; reference clock never stops
// Notes: Clocks are modelled as enables and selects, not gated clock nets
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

// Functional notes
// R1 - Five-bit core frequency select sets full speed clock; reset clears to zero.
// R2 - Codes 0 to 11 valid; higher codes unsupported and flagged.
// R3 - Effective core clock comes from full speed or half-rate memory clock.
// R4 - With switching on, memory clock only while waiting on cache fills.
// R5 - After reset switching is off and memory clock drives the core.
// R6 - Coprocessor write opcode 2 minor 2 disables switching.
// R7 - Coprocessor write opcode 2 minor 1 enables switching.
// R8 - Disabling switching freezes the current source, not forcing memory clock.
// R9 - Cache miss after disabling moves core to memory clock permanently.
// R10 - Configuration write stops both PLLs and derived clocks until relock.
// R11 - Peripheral clocks lost for about 150 microseconds after the write.
// R12 - Software should change configuration only after reset or wake-up.
// R13 - Software writes configuration before enabling switching.
// R14 - Slow 32 kHz clock and its users keep running during relock.
// R15 - Primary PLL supplies fixed serial baud clock as well.
// R16 - Peripheral clock equals full speed clock divided by two.
// R17 - Fast oscillator feeds both PLLs; secondary PLL clocks USB, infrared, multimedia.
// R18 - Slow oscillator clocks real-time clock and power manager.
// R19 - Alternative fast reference allowed; frequencies scale proportionally.
// R20 - Relock stall counted on unaffected reference, programmable interval.
module ccs_clock_ctrl
   import ccs_pkg::*;
#(
   parameter int RELOCK_CYC = CCS_RELOCK_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Core side
   input wire logic fill_wait,
   input wire logic slow_osc_run,
   // Clock controls
   output logic [4:0] core_freq_select,
   output logic effective_core_clock_full,
   output ccs_gates_s gates,
   output logic periph_clk_en,
   output logic slow_clk_run
);
   initial begin
      if (RELOCK_CYC < 1 || RELOCK_CYC >= (1 << CCS_RELOCK_W))
         $error("ccs_clock_ctrl: relock count out of range");
   end

   ccs_req_s req;
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [4:0] freq;
   logic sw_en;
   ccs_src_e src;
   logic [CCS_RELOCK_W-1:0] relock_time;
   logic stalled;
   logic half;
   logic [31:0] rdata;

   logic [4:0] next_freq;
   logic next_sw_en;
   ccs_src_e next_src;
   logic [CCS_RELOCK_W-1:0] next_relock_time;
   logic [31:0] next_rdata;
   ccs_gates_s next_gates;
   logic next_periph_en;

   logic cfg_wr;
   logic cp_wr;
   logic cp_enable;
   logic cp_disable;

   // Decode register writes
   assign cfg_wr = req.wr && (req.addr == CCS_OFF_PLL_CONFIG);
   assign cp_wr = req.wr && (req.addr == CCS_OFF_COPROC)
      && (req.wdata[CCS_CP_OPC_LSB +: 3] == CCS_OPC_CLOCK);
   assign cp_enable = cp_wr && (req.wdata[3:0] == CCS_CRM_ENABLE); // see R7
   assign cp_disable = cp_wr && (req.wdata[3:0] == CCS_CRM_DISABLE); // see R6

   // -----------------------------------------------------------------
   // Relock timer and half-rate divider
   // -----------------------------------------------------------------
   // Timer runs on clk, which is never stopped by relock
   ccs_relock_timer #(.W(CCS_RELOCK_W)) ccs_relock_timer_i (
      .clk(clk),
      .rst(rst),
      .start(cfg_wr), // see R10
      .interval(relock_time), // see R20
      .busy(stalled)
   );

   // Peripheral and memory clock is half the full speed rate
   ccs_half_div ccs_half_div_i (
      .clk(clk),
      .rst(rst),
      .run(~stalled),
      .half(half)
   );

   // -----------------------------------------------------------------
   // Configuration and source selection
   // -----------------------------------------------------------------
   // Source only moves while switching is enabled, except a miss forces memory
   always_comb begin
      next_freq = freq;
      next_sw_en = sw_en;
      next_src = src;
      next_relock_time = relock_time;
      if (cfg_wr) next_freq = req.wdata[CCS_FREQ_W-1:0]; // see R1
      if (req.wr && req.addr == CCS_OFF_RELOCK_TIME)
         next_relock_time = req.wdata[CCS_RELOCK_W-1:0];
      if (cp_enable) next_sw_en = 1'b1; // see R7
      else if (cp_disable) next_sw_en = 1'b0; // see R6
      case (sw_en)
         1'b1: next_src = fill_wait ? CCS_SRC_MEMORY : CCS_SRC_FULL; // see R4
         1'b0: if (fill_wait) next_src = CCS_SRC_MEMORY; // see R8 see R9
         default: next_src = CCS_SRC_MEMORY;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         freq <= CCS_FREQ_RESET; // see R1
         sw_en <= 1'b0; // see R5
         src <= CCS_SRC_MEMORY; // see R5
         relock_time <= CCS_RELOCK_W'(RELOCK_CYC);
      end else begin
         freq <= next_freq;
         sw_en <= next_sw_en;
         src <= next_src;
         relock_time <= next_relock_time;
      end
   end

   // -----------------------------------------------------------------
   // Clock gates
   // -----------------------------------------------------------------
   // Both PLLs and everything derived from them stop during relock
   always_comb begin
      next_gates.core_pll = ~(stalled || cfg_wr); // see R10
      next_gates.usb_pll = ~(stalled || cfg_wr); // see R10 see R17
      next_gates.baud = ~(stalled || cfg_wr); // see R15 see R11
      next_gates.periph = ~(stalled || cfg_wr); // see R11
      next_periph_en = half && !stalled && !cfg_wr; // see R16
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gates <= '0;
         periph_clk_en <= 1'b0;
         slow_clk_run <= 1'b0;
      end else begin
         gates <= next_gates;
         periph_clk_en <= next_periph_en;
         slow_clk_run <= slow_osc_run; // see R14 see R18
      end
   end

   // Registered copies of the select outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_freq_select <= CCS_FREQ_RESET;
         effective_core_clock_full <= 1'b0;
      end else begin
         core_freq_select <= next_freq;
         effective_core_clock_full <= (next_src == CCS_SRC_FULL); // see R3
      end
   end

   // -----------------------------------------------------------------
   // Register read
   // -----------------------------------------------------------------
   // Data valid only in the cycle after the read strobe
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (req.rd) begin
         case (req.addr)
            CCS_OFF_PLL_CONFIG: next_rdata[CCS_FREQ_W-1:0] = freq;
            CCS_OFF_STATUS: begin
               next_rdata[CCS_ST_STALL_BIT] = stalled;
               next_rdata[CCS_ST_SWEN_BIT] = sw_en;
               next_rdata[CCS_ST_SRC_BIT] = (src == CCS_SRC_FULL);
               next_rdata[CCS_ST_BADCODE_BIT] = (freq > CCS_FREQ_MAX_OK); // see R2
            end
            CCS_OFF_RELOCK_TIME: next_rdata[CCS_RELOCK_W-1:0] = relock_time;
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) rdata <= 32'h0000_0000;
      else rdata <= next_rdata;
   end
   assign reg_rdata = rdata;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_reset_freq_zero: assert property (@(posedge clk) $fell(rst) |-> freq == 5'h00) // see R1
      else $error("frequency select not cleared by reset");
   a_cfg_write_loads: assert property (@(posedge clk) disable iff (rst) // see R1
      cfg_wr |=> freq == $past(req.wdata[4:0]))
      else $error("frequency select not loaded");
   a_fill_uses_mem: assert property (@(posedge clk) disable iff (rst) // see R4
      sw_en && fill_wait |=> src == CCS_SRC_MEMORY)
      else $error("memory clock not used during fill");
   a_idle_uses_full: assert property (@(posedge clk) disable iff (rst) // see R4
      sw_en && !fill_wait |=> src == CCS_SRC_FULL)
      else $error("full clock not used outside fill");
   a_disable_sw: assert property (@(posedge clk) disable iff (rst) // see R6
      cp_disable |=> !sw_en)
      else $error("switching not disabled");
   a_enable_sw: assert property (@(posedge clk) disable iff (rst) // see R7
      cp_enable |=> sw_en)
      else $error("switching not enabled");
   a_frozen_src: assert property (@(posedge clk) disable iff (rst) // see R8
      !sw_en && !fill_wait |=> src == $past(src))
      else $error("source moved while frozen");
   a_miss_sticks: assert property (@(posedge clk) disable iff (rst) // see R9
      !sw_en && src == CCS_SRC_MEMORY && !cp_enable |=> src == CCS_SRC_MEMORY)
      else $error("memory clock left while disabled");
   a_relock_stall: assert property (@(posedge clk) disable iff (rst) // see R10
      cfg_wr && relock_time > 24'h2 |=> !gates.core_pll [*2])
      else $error("PLL not stopped after configuration write");
   a_periph_half: assert property (@(posedge clk) disable iff (rst) // see R16
      periph_clk_en |=> !periph_clk_en)
      else $error("peripheral enable faster than half rate");

   // Reset leaves switching off on the memory clock
   a_reset_src_mem: assert property (@(posedge clk) // see R5
      $fell(rst) |-> !effective_core_clock_full && !sw_en)
      else $error("switching or full clock live after reset");
   a_freq_output: assert property (@(posedge clk) disable iff (rst) // see R1
      cfg_wr |=> core_freq_select == $past(req.wdata[4:0]))
      else $error("frequency select output not loaded");
   a_freq_holds: assert property (@(posedge clk) disable iff (rst) // see R1
      !cfg_wr |=> freq == $past(freq))
      else $error("frequency select moved without a write");
   a_write_freq_any: assert property (@(posedge clk) disable iff (rst) // see R2
      cfg_wr && req.wdata[4:0] > CCS_FREQ_MAX_OK |=> freq > CCS_FREQ_MAX_OK)
      else $error("unsupported code not kept for the flag");

   // Source selection; when frozen only a miss can move it, and only to memory
   a_mem_half_rate: assert property (@(posedge clk) disable iff (rst) // see R3
      !stalled |=> half != $past(half))
      else $error("memory clock not at half rate");
   a_freeze_full: assert property (@(posedge clk) disable iff (rst) // see R8
      !sw_en && src == CCS_SRC_FULL && !fill_wait |=> src == CCS_SRC_FULL)
      else $error("disable forced the memory clock");
   a_fill_forces_mem: assert property (@(posedge clk) disable iff (rst) // see R9
      fill_wait |=> src == CCS_SRC_MEMORY)
      else $error("memory clock not taken on a miss");
   a_sw_holds: assert property (@(posedge clk) disable iff (rst) // see R6
      !cp_enable && !cp_disable |=> sw_en == $past(sw_en))
      else $error("switching changed without a command");
   a_other_op_ignored: assert property (@(posedge clk) disable iff (rst) // see R7
      req.wr && req.addr == CCS_OFF_COPROC
      && req.wdata[CCS_CP_OPC_LSB +: 3] != CCS_OPC_CLOCK |=> sw_en == $past(sw_en))
      else $error("other coprocessor operation touched switching");

   // Relock stall: every derived clock off, the slow clock untouched
   a_stall_after_write: assert property (@(posedge clk) disable iff (rst) // see R20
      cfg_wr |=> stalled)
      else $error("relock timer not started");
   a_write_gates_off: assert property (@(posedge clk) disable iff (rst) // see R10
      cfg_wr |=> gates == '0)
      else $error("derived clocks running after configuration write");
   a_stall_gates_off: assert property (@(posedge clk) disable iff (rst) // see R11
      stalled |=> gates == '0)
      else $error("derived clocks running during relock");
   a_gates_back: assert property (@(posedge clk) disable iff (rst) // see R10
      !stalled && !cfg_wr |=> gates == '1)
      else $error("derived clocks not restored after relock");
   a_periph_quiet: assert property (@(posedge clk) disable iff (rst) // see R11
      stalled || cfg_wr |=> !periph_clk_en)
      else $error("peripheral enable during relock");
   a_slow_runs: assert property (@(posedge clk) disable iff (rst) // see R14
      slow_osc_run |=> slow_clk_run)
      else $error("slow clock interrupted");
   a_slow_stops: assert property (@(posedge clk) disable iff (rst) // see R18
      !slow_osc_run |=> !slow_clk_run)
      else $error("slow clock run without oscillator");

   // Status read shows stall and unsupported code of the strobe cycle
   a_stall_in_status: assert property (@(posedge clk) disable iff (rst) // see R10
      req.rd && req.addr == CCS_OFF_STATUS
      |=> reg_rdata[CCS_ST_STALL_BIT] == $past(stalled))
      else $error("stall bit wrong in status");
   a_badcode_flag: assert property (@(posedge clk) disable iff (rst) // see R2
      req.rd && req.addr == CCS_OFF_STATUS
      |=> reg_rdata[CCS_ST_BADCODE_BIT] == ($past(freq) > CCS_FREQ_MAX_OK))
      else $error("unsupported code flag wrong in status");
endmodule // ccs_clock_ctrl

// *** tb/ccs_core_model.sv ***
// Purpose: Core-side partner that holds the cache-fill wait after a miss
// Assumes: One clock; the bench sets the fill length of each miss
// Notes: The fill length lets one miss be answered promptly and the next slowly
`timescale 1ns/1ps
module ccs_core_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bench command
   input wire logic miss,
   input wire logic [7:0] fill_len,
   // Core side outputs
   output logic fill_wait,
   output logic slow_osc_run
);
   logic [7:0] left;
   // -----------------------------------------------------------------
   // Fill wait and slow oscillator
   // -----------------------------------------------------------------
   // Wait level stays up for the whole fill, like real memory
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         left <= 8'h00;
         fill_wait <= 1'b0;
         slow_osc_run <= 1'b0;
      end else begin
         slow_osc_run <= 1'b1;
         if (miss) begin
            left <= fill_len;
         end else if (left != 8'h00) begin
            left <= left - 8'h01;
         end
         fill_wait <= miss || (left > 8'h01);
      end
   end
endmodule // ccs_core_model

// *** tb/ccs_clock_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for the core clock select and PLL control block
// Assumes: Short relock interval so each stall lasts a few cycles
// Notes: Software side is played by the bench through the register port
`timescale 1ns/1ps
module ccs_clock_ctrl_tb_top;
   import ccs_pkg::*;
   localparam int RELOCK = 8; // Short interval; counts scale with the reference
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic fill_wait;
   logic slow_osc_run;
   logic miss = 1'b0;
   logic [7:0] fill_len = 8'h04;
   logic [4:0] core_freq_select;
   logic effective_core_clock_full;
   ccs_gates_s gates;
   logic periph_clk_en;
   logic slow_clk_run;
   int errors = 0;
   int total_checks = 0;

   // -----------------------------------------------------------------
   // Clock, design and partner
   // -----------------------------------------------------------------
   // Four nanosecond period
   always #2 clk = ~clk;

   ccs_clock_ctrl #(.RELOCK_CYC(RELOCK)) ccs_clock_ctrl_i (.clk(clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .fill_wait(fill_wait), .slow_osc_run(slow_osc_run),
      .core_freq_select(core_freq_select),
      .effective_core_clock_full(effective_core_clock_full), .gates(gates),
      .periph_clk_en(periph_clk_en), .slow_clk_run(slow_clk_run));

   ccs_core_model ccs_core_model_i (.clk(clk), .rst(rst), .miss(miss),
      .fill_len(fill_len), .fill_wait(fill_wait), .slow_osc_run(slow_osc_run));

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   // Count every compare, report a mismatch at once
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data only stands in the cycle after the strobe
   task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(n, reg_rdata, e);
   endtask

   // Pulse a miss; the partner holds the fill wait for len cycles
   task automatic do_miss(input logic [7:0] len);
      @(posedge clk);
      fill_len <= len;
      miss <= 1'b1;
      @(posedge clk);
      miss <= 1'b0;
   endtask

   // Bounded wait for the derived clocks to come back
   task automatic wait_gates(output int n);
      n = 0;
      while (gates === 4'h0 && n < 100) begin
         n++;
         @(posedge clk);
         #1;
      end
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   // Reset state, register defaults and an unmapped place
   task automatic t_reset;
      chk("freq", core_freq_select, 5'h00);
      chk("src", effective_core_clock_full, 1'b0);
      rchk("status", CCS_OFF_STATUS, 32'h0);
      rchk("config", CCS_OFF_PLL_CONFIG, 32'h0);
      rchk("relock", CCS_OFF_RELOCK_TIME, RELOCK);
      // Read data must fall back to zero one cycle later
      @(posedge clk);
      #1;
      chk("rdata idle", reg_rdata, 32'h0);
      rchk("unmapped", 4'hF, 32'h0);
      $display("test reset done");
   endtask

   // Config write stalls the derived clocks for the whole interval
   task automatic t_relock(input logic [4:0] code, input logic bad);
      int n;
      wr(CCS_OFF_PLL_CONFIG, {27'h0, code});
      #1;
      chk("gates", gates, 4'h0);
      chk("freq", core_freq_select, code);
      chk("slow run", slow_clk_run, 1'b1);
      chk("periph", periph_clk_en, 1'b0);
      wait_gates(n);
      // Gates drop on the write edge itself, so the stall is one longer than the count
      chk("stall len", n, RELOCK + 1);
      chk("gates on", gates, 4'hF);
      rchk("status", CCS_OFF_STATUS, {28'h0, bad, 3'h0});
      rchk("config", CCS_OFF_PLL_CONFIG, {27'h0, code});
      n = periph_clk_en;
      @(posedge clk);
      #1;
      chk("periph toggle", periph_clk_en, {31'h0, ~n[0]});
      $display("test relock %h done", code);
   endtask

   // Stall shows in status; a rewrite restarts the interval
   task automatic t_stall;
      int n;
      wr(CCS_OFF_PLL_CONFIG, 32'h3);
      rchk("stall bit", CCS_OFF_STATUS, 32'h1);
      wr(CCS_OFF_PLL_CONFIG, 32'h3);
      #1;
      wait_gates(n);
      chk("restart", n, RELOCK + 1);
      // Programmed interval of three gives a four-cycle stall
      wr(CCS_OFF_RELOCK_TIME, 32'h3);
      rchk("relock set", CCS_OFF_RELOCK_TIME, 32'h3);
      wr(CCS_OFF_PLL_CONFIG, 32'h3);
      #1;
      wait_gates(n);
      chk("short stall", n, 32'h4);
      wr(CCS_OFF_RELOCK_TIME, RELOCK);
      $display("test stall done");
   endtask

   // Switching on, off, and the miss that pins the memory clock
   task automatic t_switch;
      wr(CCS_OFF_COPROC, 32'h11);
      rchk("wrong op", CCS_OFF_STATUS, 32'h0);
      wr(CCS_OFF_COPROC, 32'h21);
      repeat (3) @(posedge clk);
      #1;
      chk("full", effective_core_clock_full, 1'b1);
      do_miss(8'h06);
      repeat (2) @(posedge clk);
      #1;
      chk("mem in fill", effective_core_clock_full, 1'b0);
      repeat (8) @(posedge clk);
      #1;
      chk("full again", effective_core_clock_full, 1'b1);
      wr(CCS_OFF_STATUS, 32'hF);
      wr(CCS_OFF_COPROC, 32'h22);
      repeat (4) @(posedge clk);
      #1;
      chk("frozen full", effective_core_clock_full, 1'b1);
      rchk("status off", CCS_OFF_STATUS, 32'h4);
      do_miss(8'h02);
      repeat (12) @(posedge clk);
      #1;
      chk("pinned mem", effective_core_clock_full, 1'b0);
      $display("test switch done");
   endtask

   // Reset in mid-run drops switching and the frequency select
   task automatic t_midreset;
      wr(CCS_OFF_COPROC, 32'h21);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("reset src", effective_core_clock_full, 1'b0);
      chk("reset freq", core_freq_select, 5'h00);
      rchk("reset status", CCS_OFF_STATUS, 32'h0);
      $display("test midreset done");
   endtask

   // -----------------------------------------------------------------
   // Verdict, watchdog and main sequence
   // -----------------------------------------------------------------
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Whole run is well under a thousand cycles
   initial begin
      #20000;
      errors++;
      final_report;
   end

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      t_reset;
      t_relock(5'h0B, 1'b0);
      t_relock(5'h0C, 1'b1);
      t_relock(5'h05, 1'b0);
      t_stall;
      t_switch;
      t_midreset;
      final_report;
   end
endmodule // ccs_clock_ctrl_tb_top
